// file: src/mcb_pkg.sv
package mcb_pkg;

	localparam int STS_W = 64;
	localparam int ADDR_W = 64;
	localparam int MISC_W = 64;
	localparam int CNT_W = 15;

	localparam int ARCH_CODE_LSB = 0;
	localparam int ARCH_CODE_MSB = 15;
	localparam int IMPL_CODE_LSB = 16;
	localparam int IMPL_CODE_MSB = 31;
	localparam int OTHER_LSB = 32;
	localparam int OTHER_MSB = 37;
	localparam int CNT_LSB = 38;
	localparam int CNT_MSB = 52;
	localparam int HEALTH_LSB = 53;
	localparam int HEALTH_MSB = 54;
	localparam int ACTION_BIT = 55;
	localparam int SIGNAL_BIT = 56;
	localparam int CORRUPT_BIT = 57;
	localparam int ADDRESS_VALID_FLAG_BIT = 58;
	localparam int MISC_VALID_FLAG_BIT = 59;
	localparam int ENABLED_BIT = 60;
	localparam int UNCORR_BIT = 61;
	localparam int OVERFLOW_BIT = 62;
	localparam int VALID_BIT = 63;

	localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;
	localparam logic [63:0] ADDR_RESET = 64'h0000_0000_0000_0000;

	localparam logic [1:0] HEALTH_NONE = 2'h0;
	localparam logic [1:0] HEALTH_GREEN = 2'h1;
	localparam logic [1:0] HEALTH_YELLOW = 2'h2;

	typedef enum logic [1:0] {
		MCB_SEL_STATUS,
		MCB_SEL_ADDR,
		MCB_SEL_MISC,
		MCB_SEL_NONE
	} mcb_sel_t;

endpackage

// file: src/mcb_bank.sv
// How it works
// - Logging an error sets the valid flag, bit 63; only software clears it.
// - Status is cleared by writing zeros; a write holding any one faults.
// - Architecture error code of the condition goes to status bits 15:0.
// - Implementation error code identifying the condition goes to bits 31:16.
// - Bits 37:32 carry implementation-specific extra information.
// - With counting capability, bits 52:38 count corrected errors until cleared.
// - Counter top bit 52 is a sticky overflow indicator.
// - Without threshold, bits 56:53 are implementation info; without recovery, 56:55 reserved.
// - With recovery and threshold capability, bit 56 flags a reported recoverable uncorrected error.
// - With recovery and threshold capability, bit 55 flags required software recovery action.
// - Corrected errors with threshold: bits 54:53 hold none, green or yellow.
// - Bit 57 set when processor state may be corrupted, else cleared.
// - Bit 58 set only when the address register holds the error address.
// - Bit 59 set only when the misc register holds extra information.
// - Bit 60 set when the error was enabled by its control enable bit.
// - Bit 61 set for uncorrected errors, cleared for corrected ones.
// - A new error while valid is set sets overflow bit 62; software clears.
// - Enabled beats disabled, uncorrected beats corrected; uncorrected replaces uncorrected only when enabled over disabled.
// - Green or untracked entry yields to corrected errors; yellow kept against green.
// - Replacement takes all guarded fields from the new event; kept entry stays whole.
// - Health colour only for monitored structures, otherwise code 00.
// - Address register faults if absent; if present, zeros clear and ones fault.
`timescale 1ns/1ps
`default_nettype none

module mcb_bank
	import mcb_pkg::*;
#(
	parameter bit CAP_COUNT     = 1'b1,
	parameter bit CAP_THRESHOLD = 1'b1,
	parameter bit CAP_RECOVERY  = 1'b1,
	parameter bit ADDR_PRESENT  = 1'b1,
	parameter bit MISC_PRESENT  = 1'b1
) (
	input  wire logic              clock,        // System clock, 100 MHz.
	input  wire logic              rst,          // Synchronous reset, active high.
	input  wire logic              err_valid,    // Error report strobe from the unit.
	input  wire logic [15:0]       err_arch_code, // Architecture error code.
	input  wire logic [15:0]       err_impl_code, // Implementation error code.
	input  wire logic [5:0]        err_other,    // Implementation extra information.
	input  wire logic [3:0]        err_impl_hi,  // Implementation info for bits 56:53.
	input  wire logic              err_uncorrected, // Error not corrected.
	input  wire logic              err_enabled,  // Per-error enable bit was set.
	input  wire logic              err_corrupt,  // Processor context may be corrupt.
	input  wire logic              err_monitored, // Source structure is health-tracked.
	input  wire logic              err_yellow,   // Tracked structure is above threshold.
	input  wire logic              err_recoverable, // Uncorrected error is recoverable.
	input  wire logic              err_action,   // Software recovery action required.
	input  wire logic              err_addr_ok,  // Address input is valid.
	input  wire logic [ADDR_W-1:0] err_addr,     // Error address.
	input  wire logic              err_misc_ok,  // Misc input is valid.
	input  wire logic [MISC_W-1:0] err_misc,     // Error extra information.
	input  wire logic              reg_rd,       // Register read strobe.
	input  wire logic              reg_wr,       // Register write strobe.
	input  wire logic [1:0]        reg_sel,      // Register select.
	input  wire logic [63:0]       reg_wdata,    // Write data.
	output logic      [63:0]       reg_rdata,    // Read data.
	output logic                   reg_fault,    // General-protection fault pulse.
	output logic      [STS_W-1:0]  status_out,   // Live status register.
	output logic      [ADDR_W-1:0] addr_out,     // Live address register.
	output logic      [MISC_W-1:0] misc_out      // Live misc register.
);

	// Stored registers and their next values.
	logic [STS_W-1:0]  status_q;
	logic [STS_W-1:0]  status_d;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;
	logic [MISC_W-1:0] misc_q;
	logic [MISC_W-1:0] misc_d;
	logic [63:0]       rdata_q;
	logic [63:0]       rdata_d;
	logic              fault_q;
	logic              fault_d;

	mcb_sel_t sel;
	assign sel = mcb_sel_t'(reg_sel);

	// Access decode; a refused access changes nothing but the fault pulse.
	wire acc;
	wire sel_absent;
	wire wr_nonzero;
	wire bad_access;
	wire clr_status;
	wire clr_addr;
	wire clr_misc;

	assign acc        = reg_rd | reg_wr;
	assign sel_absent = (sel == MCB_SEL_NONE) ||
	                    (sel == MCB_SEL_ADDR && !ADDR_PRESENT) ||
	                    (sel == MCB_SEL_MISC && !MISC_PRESENT);
	assign wr_nonzero = reg_wr && (reg_wdata != 64'h0000_0000_0000_0000);
	assign bad_access = acc && (sel_absent || wr_nonzero);

	// Only an all-zero write to a present register clears it.
	assign clr_status = reg_wr && !bad_access && sel == MCB_SEL_STATUS;
	assign clr_addr   = reg_wr && !bad_access && sel == MCB_SEL_ADDR;
	assign clr_misc   = reg_wr && !bad_access && sel == MCB_SEL_MISC;

	wire old_valid   = status_q[VALID_BIT];
	wire old_uc      = status_q[UNCORR_BIT];
	wire old_en      = status_q[ENABLED_BIT];
	wire old_yellow  = CAP_THRESHOLD && status_q[HEALTH_MSB:HEALTH_LSB] == HEALTH_YELLOW;
	wire new_yellow  = CAP_THRESHOLD && err_monitored && err_yellow;

	// Overwrite priority: enable first, then uncorrected, then colour.
	wire en_wins     = err_enabled && !old_en;
	wire en_loses    = !err_enabled && old_en;
	wire uc_held     = old_uc;
	wire uc_new      = err_uncorrected;
	wire yellow_held = old_yellow && !new_yellow;
	wire rank_keep   = en_loses || uc_held || (!uc_new && yellow_held);

	// Decides whether a new event displaces a valid entry.
	wire replace_w   = !old_valid || en_wins || !rank_keep;

	// A zero write landing with an event loses, so the event is logged whole.
	wire take_new    = replace_w || clr_status;

	// Health colour field: none unless monitored, yellow or green otherwise.
	wire [1:0] health_w = !err_monitored ? HEALTH_NONE :
	                      (err_yellow ? HEALTH_YELLOW : HEALTH_GREEN);

	wire [3:0] hi_w = !CAP_THRESHOLD ? err_impl_hi :
	                  {CAP_RECOVERY && err_uncorrected && err_recoverable,
	                   CAP_RECOVERY && err_uncorrected && err_action,
	                   err_uncorrected ? 2'h0 : health_w};

	// Corrected-error counter; the top bit latches once the low bits wrap.
	wire [CNT_W-1:0] cnt_old;
	wire [CNT_W-2:0] cnt_low;
	wire             cnt_top;
	wire             count_hit;
	wire [CNT_W-1:0] cnt_inc;
	wire [CNT_W-1:0] cnt_w;
	wire [CNT_W-1:0] cnt_field;

	assign cnt_old   = status_q[CNT_MSB:CNT_LSB];
	assign cnt_low   = cnt_old[CNT_W-2:0] + (CNT_W-1)'(1);
	assign cnt_top   = cnt_old[CNT_W-1] | (&cnt_old[CNT_W-2:0]);
	assign cnt_inc   = {cnt_top, cnt_low};
	assign count_hit = CAP_COUNT && err_valid && !err_uncorrected;
	assign cnt_w     = count_hit ? cnt_inc : cnt_old;

	// Without counting these bits are zero in a replacing entry and otherwise keep their old value.
	assign cnt_field = CAP_COUNT ? cnt_w : (replace_w ? 15'h0000 : cnt_old);

	// Status fields of a new entry, most significant first.
	wire             fld_valid   = 1'b1;
	wire             fld_over    = old_valid;
	wire             fld_uc      = err_uncorrected;
	wire             fld_en      = err_enabled;
	wire             fld_misc_valid_flag   = MISC_PRESENT && err_misc_ok;
	wire             fld_address_valid_flag   = ADDR_PRESENT && err_addr_ok;
	wire             fld_corrupt = err_corrupt;
	wire [3:0]       fld_hi      = hi_w;
	wire [CNT_W-1:0] fld_cnt     = cnt_field;
	wire [5:0]       fld_other   = err_other;
	wire [15:0]      fld_impl    = err_impl_code;
	wire [15:0]      fld_arch    = err_arch_code;

	wire [STS_W-1:0] new_status = {fld_valid,
	                               fld_over,
	                               fld_uc,
	                               fld_en,
	                               fld_misc_valid_flag,
	                               fld_address_valid_flag,
	                               fld_corrupt,
	                               fld_hi,
	                               fld_cnt,
	                               fld_other,
	                               fld_impl,
	                               fld_arch};

	always_comb begin
		status_d = status_q;
		addr_d   = addr_q;
		misc_d   = misc_q;
		if (clr_status) begin
			status_d = STATUS_RESET;
		end
		if (clr_addr) begin
			addr_d = ADDR_RESET;
		end
		if (clr_misc) begin
			misc_d = ADDR_RESET;
		end
		// A logged event wins over a software clear in the same cycle.
		if (err_valid) begin
			if (take_new) begin
				status_d = new_status;
				if (old_valid) begin
					status_d[OVERFLOW_BIT] = 1'b1;
				end
				addr_d = (ADDR_PRESENT && err_addr_ok) ? err_addr : ADDR_RESET;
				misc_d = (MISC_PRESENT && err_misc_ok) ? err_misc : ADDR_RESET;
			end else begin
				status_d[OVERFLOW_BIT] = 1'b1;
				if (CAP_COUNT) begin
					status_d[CNT_MSB:CNT_LSB] = cnt_w;
				end
			end
		end
	end

	// Read data mux; a refused or absent read leaves the last word standing.
	wire [63:0]  rd_status = status_q;
	wire [63:0]  rd_addr   = ADDR_PRESENT ? addr_q : 64'h0000_0000_0000_0000;
	wire [63:0]  rd_misc   = MISC_PRESENT ? misc_q : 64'h0000_0000_0000_0000;
	wire         rd_take   = reg_rd && !bad_access;
	logic [63:0] rd_mux;

	always_comb begin
		case (sel)
			MCB_SEL_STATUS: rd_mux = rd_status;
			MCB_SEL_ADDR:   rd_mux = rd_addr;
			MCB_SEL_MISC:   rd_mux = rd_misc;
			default:        rd_mux = 64'h0000_0000_0000_0000;
		endcase
	end

	assign rdata_d = rd_take ? rd_mux : rdata_q;
	assign fault_d = bad_access;

	// Capabilities are parameters, so they cannot change after reset.
	always_ff @(posedge clock) begin
		if (rst) begin
			status_q <= STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			addr_q <= ADDR_RESET;
		end else begin
			addr_q <= addr_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			misc_q <= ADDR_RESET;
		end else begin
			misc_q <= misc_d;
		end
	end

	// Read data holds between good reads.
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= 64'h0000_0000_0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Fault is a one-cycle pulse after the refused access.
	always_ff @(posedge clock) begin
		if (rst) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= fault_d;
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_fault  = fault_q;
	assign status_out = status_q;
	assign addr_out   = addr_q;
	assign misc_out   = misc_q;

endmodule

`default_nettype wire

// file: tb/mcb_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_bank_assertions (
	input wire logic        clock,           // Clock.
	input wire logic        rst,             // Reset.
	input wire logic        err_valid,       // Strobe.
	input wire logic        err_uncorrected, // Uncorrected.
	input wire logic        err_enabled,     // Enabled.
	input wire logic        err_monitored,   // Tracked.
	input wire logic [15:0] err_arch_code,   // Code.
	input wire logic        reg_wr,          // Write.
	input wire logic [1:0]  reg_sel,         // Select.
	input wire logic [63:0] reg_wdata,       // Data.
	input wire logic        reg_fault,       // Fault.
	input wire logic [63:0] status_out       // Status.
);
	logic clr;
	assign clr = reg_wr && reg_sel == 2'h0 && reg_wdata == 64'h0;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_val; err_valid |=> status_out[63]; endproperty
	a_val: assert property (p_val) else $error("valid not set");
	property p_ovr; err_valid && status_out[63] |-> ##1 status_out[62]; endproperty
	a_ovr: assert property (p_ovr) else $error("overflow not set");
	property p_code; err_valid && !status_out[63] |=> status_out[15:0] == $past(err_arch_code); endproperty
	a_code: assert property (p_code) else $error("code not logged");
	property p_keep; err_valid && err_uncorrected && status_out[63] && status_out[61] && !clr
		&& (status_out[60] || !err_enabled)
		|=> $stable(status_out[15:0]); endproperty
	a_keep: assert property (p_keep) else $error("uncorrected entry replaced");
	property p_hlth; err_valid && !status_out[63] && !err_uncorrected && !err_monitored |=> status_out[54:53] == 2'h0; endproperty
	a_hlth: assert property (p_hlth) else $error("colour posted");
	property p_stk; status_out[52] && !clr |=> status_out[52]; endproperty
	a_stk: assert property (p_stk) else $error("count overflow lost");
	property p_flt; reg_wr && reg_wdata != 64'h0 && !err_valid |=> reg_fault && $stable(status_out); endproperty
	a_flt: assert property (p_flt) else $error("nonzero write accepted");
	property p_clr; clr && !err_valid |=> status_out == 64'h0 && !reg_fault; endproperty
	a_clr: assert property (p_clr) else $error("zero write failed");
	c_ovr: cover property (err_valid && status_out[63]);
	c_flt: cover property (reg_fault);
	c_wrap: cover property (status_out[52]);
endmodule
bind mcb_bank mcb_bank_assertions mcb_bank_assertions_i (.clock(clock), .rst(rst), .err_valid(err_valid),
	.err_uncorrected(err_uncorrected), .err_enabled(err_enabled), .err_monitored(err_monitored),
	.err_arch_code(err_arch_code),
	.reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_fault(reg_fault), .status_out(status_out));
`default_nettype wire

// file: tb/mcb_err_src.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_err_src (
	input  wire logic        clock, // Clock.
	output logic             vld,   // Error strobe.
	output logic [41:0]      code,  // Impl hi, other, impl, arch.
	output logic [8:0]       f,     // Event attribute flags.
	output logic [63:0]      adr    // Address, misc is its inverse.
);
	initial {vld, code, f, adr} = '0;
	// One-cycle report; afterwards the fields turn to garbage as a real unit may.
	task automatic send(input logic [41:0] k, input logic [8:0] g, input logic [63:0] d);
		@(posedge clock);
		#1;
		{vld, code, f, adr} = {1'b1, k, g, d};
		@(posedge clock);
		#1;
		{vld, code, f, adr} = {1'b0, ~k, ~g, ~d};
	endtask
endmodule
`default_nettype wire

// file: tb/mcb_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_bank_tb;
	import mcb_pkg::*;
	logic        clock = 1'b0;
	logic        rst, rd, wr, vld, flt;
	logic [1:0]  sel;
	logic [8:0]  f, g;
	logic [41:0] code;
	logic [63:0] wd, rdat, st, ao, mo, adr, c, a;
	int          err_count, n_checks;
	logic [8:0]  p1 [7] = '{9'h0A0, 9'h0A0, 9'h0B0, 9'h0A0, 9'h180, 9'h180, 9'h020};
	logic [8:0]  p2 [7] = '{9'h0A0, 9'h0B0, 9'h0A0, 9'h180, 9'h0A0, 9'h180, 9'h0A0};
	logic [6:0]  keep = 7'b0110100;
	always #5 clock = ~clock;
	mcb_err_src mcb_err_src_i (.clock(clock), .vld(vld), .code(code), .f(f), .adr(adr));
	mcb_bank mcb_bank_i (.clock(clock), .rst(rst), .err_valid(vld), .err_arch_code(code[15:0]),
		.err_impl_code(code[31:16]), .err_other(code[37:32]), .err_impl_hi(code[41:38]), .err_uncorrected(f[8]),
		.err_enabled(f[7]), .err_corrupt(f[6]), .err_monitored(f[5]), .err_yellow(f[4]), .err_recoverable(f[3]),
		.err_action(f[2]), .err_addr_ok(f[1]), .err_addr(adr), .err_misc_ok(f[0]), .err_misc(~adr), .reg_rd(rd),
		.reg_wr(wr), .reg_sel(sel), .reg_wdata(wd), .reg_rdata(rdat), .reg_fault(flt), .status_out(st),
		.addr_out(ao), .misc_out(mo));
	function automatic logic [63:0] fresh(input logic [41:0] k, input logic [8:0] e);
		logic [63:0] s;
		s = {1'b1, 1'b0, e[8], e[7], e[0], e[1], e[6], e[8] & e[3], e[8] & e[2], 2'h0, 14'h0, ~e[8], k[37:0]};
		if (!e[8] && e[5])
			s[54:53] = e[4] ? HEALTH_YELLOW : HEALTH_GREEN;
		return s;
	endfunction
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] v);
		n_checks++;
		if (v !== e) begin
			err_count++;
			$display("ERROR %s expected %h got %h", n, e, v);
		end
	endtask
	task automatic acc(input logic r, input logic w, input logic [1:0] s, input logic [63:0] d);
		@(posedge clock);
		#1;
		{rd, wr, sel, wd} = {r, w, s, d};
		@(posedge clock);
		#1;
		{rd, wr, wd} = {2'b00, ~d};
	endtask
	task automatic print_verdict;
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{rst, rd, wr, sel, wd, err_count, n_checks} = {1'b1, 2'b00, 2'h0, 64'h0, 32'd0, 32'd0};
		void'($urandom(40));
		repeat (12) @(posedge clock);
		#1;
		rst = 1'b0;
		chk("status_reset", STATUS_RESET, st);
		for (int i = 0; i < 40; i++) begin
			c = {$urandom, $urandom};
			a = {$urandom, $urandom};
			g = (i == 0) ? 9'h1FF : 9'($urandom);
			mcb_err_src_i.send(c[41:0], g, a);
			chk("status", fresh(c[41:0], g), st);
			chk("addr", g[1] ? a : 64'h0, ao);
			chk("misc", g[0] ? ~a : 64'h0, mo);
			acc(1'b1, 1'b0, 2'h0, 64'h0);
			chk("read", fresh(c[41:0], g), rdat);
			acc(1'b0, 1'b1, 2'(i % 3), 64'h1 << (i % 64));
			chk("fault", 64'h1, {63'h0, flt});
			chk("kept", fresh(c[41:0], g), st);
			acc(1'b0, 1'b1, 2'h0, 64'h0);
			chk("cleared", 64'h0, st);
		end
		acc(1'b0, 1'b1, 2'h1, 64'h0);
		chk("addr_clear", 64'h0, ao);
		acc(1'b1, 1'b0, 2'h3, 64'h0);
		chk("sel_fault", 64'h1, {63'h0, flt});
		for (int i = 0; i < 7; i++) begin
			mcb_err_src_i.send(42'h1111, p1[i], a);
			mcb_err_src_i.send(42'h2222, p2[i], a);
			chk("winner", keep[i] ? 64'h1111 : 64'h2222, {48'h0, st[15:0]});
			chk("over", 64'h1, {63'h0, st[62]});
			chk("count", 64'(!p1[i][8]) + 64'(!p2[i][8]), {49'h0, st[52:38]});
			acc(1'b0, 1'b1, 2'h0, 64'h0);
		end
		repeat (16384) mcb_err_src_i.send(42'h0, 9'h080, a);
		chk("wrap", 64'h4000, {49'h0, st[52:38]});
		mcb_err_src_i.send(42'h0, 9'h080, a);
		chk("sticky", 64'h4001, {49'h0, st[52:38]});
		print_verdict();
	end
endmodule
`default_nettype wire
